// File: lmbi_pkg.sv
// constants shared by both ends of the local microcontroller bus
`default_nettype none
package lmbi_pkg;
  // ------------------------------------------------------------
  // device address map
  // ------------------------------------------------------------
  localparam logic [7:0] DEC_LO       = 8'h20;
  localparam logic [7:0] OVL_LO       = 8'h20;
  localparam logic [7:0] OVL_HI       = 8'h3e;
  localparam logic [7:0] OVL_DST_LO   = 8'ha0;
  localparam logic [7:0] OVL_DST_HI   = 8'hbe;
  localparam logic [7:0] OVL_SHIFT    = 8'h80;
  localparam logic [7:0] OFF_AUX0     = 8'h48;
  localparam logic [7:0] OFF_AUX1     = 8'h4f;
  localparam logic [7:0] OFF_MISC     = 8'h52;
  localparam logic [7:0] OFF_SH_BUF   = 8'h53;
  localparam logic [7:0] OFF_SCHED    = 8'h68;
  localparam logic [7:0] OFF_UNSCHED  = 8'h70;
  localparam logic [7:0] OFF_SH_ECC   = 8'h71;
  localparam logic [7:0] OFF_UNLOCK   = 8'h73;
  localparam logic [7:0] OFF_IST_LO   = 8'h5a;
  localparam logic [7:0] OFF_IST_HI   = 8'h5b;
  localparam logic [7:0] OFF_IMSK_LO  = 8'h5c;
  localparam logic [7:0] OFF_IMSK_HI  = 8'h5d;
  localparam logic [7:0] OFF_ICTL     = 8'h5e;
  localparam logic [7:0] OFF_PTR_LO   = 8'h5f;
  localparam logic [7:0] OFF_PTR_HI   = 8'h58;
  localparam logic [7:0] IDX_SH_BUF   = 8'h13;
  localparam logic [7:0] IDX_SH_ECC   = 8'h11;
  localparam logic [7:0] HRF_MASK     = 8'hf8;
  localparam logic [7:0] HRF_BASE0    = 8'h40;
  localparam logic [7:0] HRF_BASE1    = 8'h60;
  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int AUX0_AINC     = 0;
  localparam int AUX0_SHADOW   = 1;
  localparam int MISC_MOE_DIS  = 0;
  localparam int AUX1_OVL      = 0;
  localparam int AUX1_HRF_SEL  = 1;
  localparam int AUX1_PD_LOCAL = 5;
  localparam int AUX1_PD_ATA   = 6;
  localparam int AUX1_PD_DEEP  = 7;
  localparam int ICTL_GLOBAL   = 0;
  localparam int ICTL_OD       = 1;
  localparam int BD_STYLE      = 6;
  localparam int BD_MUX        = 7;
  localparam int N_SW          = 5;
  localparam int N_IRQ         = 12;
  localparam logic [7:0] REG_RST = 8'h00;
  // ------------------------------------------------------------
  // controller command registers and timing
  // ------------------------------------------------------------
  localparam logic [1:0] H_ADDR  = 2'h0;
  localparam logic [1:0] H_WDATA = 2'h1;
  localparam logic [1:0] H_CTRL  = 2'h2;
  localparam logic [1:0] H_RDATA = 2'h3;
  localparam int HC_GO   = 0;
  localparam int HC_READ = 1;
  localparam int HC_MOTO = 2;
  localparam int HC_MUX  = 3;
  localparam int CLK_NS    = 100;
  localparam int PHASE_NS  = 300;
  localparam logic [3:0] PHASE_CYC =
    4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_ALE  = 5'b00010,
    H_GAP  = 5'b00100,
    H_STRB = 5'b01000,
    H_END  = 5'b10000
  } lmbi_hstate_t;
endpackage
`default_nettype wire

// File: lmbi_if.sv
// pins between the microcontroller end and the device end
`default_nettype none
interface lmbi_if;
  logic       ale;
  logic [7:0] addr;
  logic [7:0] ad_m;
  logic       ad_m_oe;
  logic [7:0] ad_d;
  logic       ad_d_oe;
  logic       write_dir_n;
  logic       read_or_data_strobe;
  logic [7:0] bd;
  logic [7:0] ad;
  // undriven bus floats high through the board pull-ups
  assign ad = ad_d_oe ? ad_d : (ad_m_oe ? ad_m : 8'hff);
  modport dev (input ale, addr, ad, write_dir_n, read_or_data_strobe, bd,
               output ad_d, ad_d_oe);
  modport mcu (input ad,
               output ale, addr, ad_m, ad_m_oe, write_dir_n,
               read_or_data_strobe);
endinterface
`default_nettype wire

// File: lmbi_dev.sv
// device end: bus slave, register map, buffer ports, power-down
`default_nettype none
// Function
// - separate style, write strobe alone times writes
// - separate style, read strobe times read drive
// - style strap high selects separate strobes
// - direction style, pin high read, low write
// - direction style, drive at strobe rise, capture at fall
// - mux strap high selects multiplexed bus
// - five low buffer lines are readable switches
// - decode 20h through ffh except overlaid 20h-3eh and any host file window not enabled
// - optional overlay of 20h-3eh onto a0h-beh
// - shadow select bit reaches shadow 53h/71h
// - host file disabled until base programmed
// - masks, global enable, open-drain or push-pull
// - twelve listed interrupt sources
// - switches read at 68h/70h with disable bit
// - 68h access is scheduled, pointer addressed
// - 68h access advances pointer when enabled
// - 70h only when no transfer or correction
// - 4fh bits 5,6,7 select power-down levels
// - deep sleep wakes only on pin reset
// - ata power-down wakes on soft or pin reset
// - local power-down wakes on host command too
// - bit 5 locked after a local wake until unlock write
module lmbi_dev (
  input  wire logic                       clock,
  input  wire logic                       rst,
  lmbi_if.dev                             bus,
  input  wire logic                       host_reset_pin,
  input  wire logic                       host_cmd_wr,
  input  wire logic                       host_soft_reset,
  input  wire logic [lmbi_pkg::N_IRQ-1:0] irq_src,
  output logic                            irq_o,
  output logic                            irq_oe,
  output logic                            buf_req,
  output logic                            buf_sched,
  output logic                            buf_we,
  output logic [15:0]                     buf_addr,
  output logic [7:0]                      buf_wdata,
  input  wire logic                       buf_ack,
  input  wire logic [7:0]                 buf_rdata,
  output logic                            pd_local,
  output logic                            pd_ata,
  output logic                            pd_deep,
  output logic                            sep_strobe,
  output logic                            mux_mode
);
  import lmbi_pkg::*;

  logic             strap_done_r;
  logic             wr_p_r;
  logic             ds_p_r;
  logic             drv_p_r;
  logic [7:0]       addr_r;
  logic [7:0]       aux0_r;
  logic [7:0]       aux1_r;
  logic [7:0]       misc_r;
  logic [N_IRQ-1:0] ist_r;
  logic [N_IRQ-1:0] imsk_r;
  logic [1:0]       ictl_r;
  logic [15:0]      ptr_r;
  logic [7:0]       latch_r;
  logic             lock_r;
  logic             hrf_en_r;
  logic [7:0]       mem_r [256];
  logic [7:0]       cur_a;
  logic [7:0]       idx;
  logic [7:0]       rd_val;
  logic [7:0]       wdata;
  logic             hit;
  logic             generic;
  logic             drv;
  logic             rd_go;
  logic             wr_go;
  logic             buf_hit;
  logic [N_IRQ-1:0] ist_clr;
  logic             pend;
  logic             wake_local;

  // ------------------------------------------------------------
  // straps
  // ------------------------------------------------------------
  // captured on the first edge after release, never under reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_done_r <= 1'b0;
      sep_strobe   <= 1'b0;
      mux_mode     <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      sep_strobe   <= bus.bd[BD_STYLE];
      mux_mode     <= bus.bd[BD_MUX];
    end
  end

  // ------------------------------------------------------------
  // strobe decode
  // ------------------------------------------------------------
  always_comb begin
    wdata = bus.ad;
    cur_a = mux_mode ? addr_r : bus.addr;
    if (sep_strobe) begin
      drv   = !bus.read_or_data_strobe;
      wr_go = bus.write_dir_n && !wr_p_r;
    end else begin
      drv   = bus.read_or_data_strobe && bus.write_dir_n;
      wr_go = !bus.read_or_data_strobe && ds_p_r &&
              !bus.write_dir_n;
    end
    wr_go = wr_go && strap_done_r;
    drv   = drv && strap_done_r;
    rd_go = drv && !drv_p_r;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_p_r  <= 1'b1;
      ds_p_r  <= 1'b0;
      drv_p_r <= 1'b0;
      addr_r  <= 8'h00;
    end else begin
      wr_p_r  <= bus.write_dir_n;
      ds_p_r  <= bus.read_or_data_strobe;
      drv_p_r <= drv;
      if (mux_mode && bus.ale)
        addr_r <= bus.ad;
    end
  end

  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  always_comb begin
    idx = cur_a;
    hit = (cur_a >= DEC_LO);
    if (aux1_r[AUX1_OVL]) begin
      if (cur_a >= OVL_LO && cur_a <= OVL_HI)
        hit = 1'b0;
      if (cur_a >= OVL_DST_LO && cur_a <= OVL_DST_HI)
        idx = cur_a - OVL_SHIFT;
    end
    if (aux0_r[AUX0_SHADOW] && cur_a == OFF_SH_BUF)
      idx = IDX_SH_BUF;
    if (aux0_r[AUX0_SHADOW] && cur_a == OFF_SH_ECC)
      idx = IDX_SH_ECC;
    if ((cur_a & HRF_MASK) == HRF_BASE0)
      hit = hit && hrf_en_r && !aux1_r[AUX1_HRF_SEL];
    if ((cur_a & HRF_MASK) == HRF_BASE1)
      hit = hit && hrf_en_r && aux1_r[AUX1_HRF_SEL];
    buf_hit = (cur_a == OFF_SCHED) || (cur_a == OFF_UNSCHED);
    generic = 1'b1;
    rd_val  = mem_r[idx];
    case (cur_a)
      OFF_AUX0:    rd_val = aux0_r;
      OFF_AUX1:    rd_val = aux1_r;
      OFF_MISC:    rd_val = misc_r;
      OFF_IST_LO:  rd_val = ist_r[7:0];
      OFF_IST_HI:  rd_val = {4'h0, ist_r[N_IRQ-1:8]};
      OFF_IMSK_LO: rd_val = imsk_r[7:0];
      OFF_IMSK_HI: rd_val = {4'h0, imsk_r[N_IRQ-1:8]};
      OFF_ICTL:    rd_val = {6'h00, ictl_r};
      OFF_PTR_LO:  rd_val = ptr_r[7:0];
      OFF_PTR_HI:  rd_val = ptr_r[15:8];
      OFF_UNLOCK:  rd_val = 8'h00;
      OFF_SCHED, OFF_UNSCHED: begin
        if (misc_r[MISC_MOE_DIS])
          rd_val = {3'h0, bus.bd[N_SW-1:0]};
        else
          rd_val = latch_r;
      end
      default:     rd_val = mem_r[idx];
    endcase
    case (cur_a)
      OFF_AUX0, OFF_AUX1, OFF_MISC, OFF_IST_LO, OFF_IST_HI, OFF_IMSK_LO,
      OFF_IMSK_HI, OFF_ICTL, OFF_PTR_LO, OFF_PTR_HI, OFF_UNLOCK,
      OFF_SCHED, OFF_UNSCHED: generic = 1'b0;
      default: generic = 1'b1;
    endcase
  end

  // ------------------------------------------------------------
  // read data drive
  // ------------------------------------------------------------
  // kept live while driving so a late buffer fetch still shows
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus.ad_d    <= 8'h00;
      bus.ad_d_oe <= 1'b0;
    end else begin
      bus.ad_d    <= rd_val;
      bus.ad_d_oe <= drv && hit;
    end
  end

  always_ff @(posedge clock) begin
    if (wr_go && hit && generic)
      mem_r[idx] <= wdata;
  end

  // ------------------------------------------------------------
  // control registers and power-down
  // ------------------------------------------------------------
  assign wake_local = host_cmd_wr || host_reset_pin || host_soft_reset;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aux0_r   <= REG_RST;
      aux1_r   <= REG_RST;
      misc_r   <= REG_RST;
      ictl_r   <= 2'h0;
      imsk_r   <= '0;
      lock_r   <= 1'b0;
      hrf_en_r <= 1'b0;
    end else begin
      if (wr_go && hit) begin
        case (cur_a)
          OFF_AUX0:    aux0_r <= wdata;
          OFF_MISC:    misc_r <= wdata;
          OFF_ICTL:    ictl_r <= wdata[1:0];
          OFF_IMSK_LO: imsk_r[7:0] <= wdata;
          OFF_IMSK_HI: imsk_r[N_IRQ-1:8] <= wdata[3:0];
          OFF_UNLOCK:  lock_r <= 1'b0;
          OFF_AUX1: begin
            aux1_r   <= wdata;
            hrf_en_r <= 1'b1;
            if (lock_r)
              aux1_r[AUX1_PD_LOCAL] <= aux1_r[AUX1_PD_LOCAL];
          end
          default: ;
        endcase
      end
      if (host_reset_pin)
        aux1_r[AUX1_PD_DEEP] <= 1'b0;
      if (host_reset_pin || host_soft_reset)
        aux1_r[AUX1_PD_ATA] <= 1'b0;
      if (aux1_r[AUX1_PD_LOCAL] && wake_local) begin
        aux1_r[AUX1_PD_LOCAL] <= 1'b0;
        lock_r <= 1'b1;
      end
    end
  end

  always_comb begin
    pd_local = aux1_r[AUX1_PD_LOCAL];
    pd_ata   = aux1_r[AUX1_PD_ATA];
    pd_deep  = aux1_r[AUX1_PD_DEEP];
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  always_comb begin
    ist_clr = '0;
    if (wr_go && hit && cur_a == OFF_IST_LO)
      ist_clr[7:0] = wdata;
    if (wr_go && hit && cur_a == OFF_IST_HI)
      ist_clr[N_IRQ-1:8] = wdata[3:0];
    pend = ictl_r[ICTL_GLOBAL] && |(ist_r & imsk_r);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ist_r  <= '0;
      irq_o  <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      ist_r  <= (ist_r & ~ist_clr) | irq_src;
      irq_o  <= ictl_r[ICTL_OD] ? 1'b0 : pend;
      irq_oe <= ictl_r[ICTL_OD] ? pend : 1'b1;
    end
  end

  // ------------------------------------------------------------
  // buffer ports
  // ------------------------------------------------------------
  // one access in flight; a second one before the ack is dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buf_req   <= 1'b0;
      buf_sched <= 1'b0;
      buf_we    <= 1'b0;
      buf_addr  <= 16'h0000;
      buf_wdata <= 8'h00;
      latch_r   <= 8'h00;
      ptr_r     <= 16'h0000;
    end else begin
      if (wr_go && hit && cur_a == OFF_PTR_LO)
        ptr_r[7:0] <= wdata;
      if (wr_go && hit && cur_a == OFF_PTR_HI)
        ptr_r[15:8] <= wdata;
      if (buf_req && buf_ack) begin
        buf_req <= 1'b0;
        if (!buf_we)
          latch_r <= buf_rdata;
      end
      if (!buf_req && hit && buf_hit &&
          (wr_go || (rd_go && !misc_r[MISC_MOE_DIS]))) begin
        buf_req   <= 1'b1;
        buf_sched <= (cur_a == OFF_SCHED);
        buf_we    <= wr_go;
        buf_addr  <= ptr_r;
        buf_wdata <= wdata;
        if (cur_a == OFF_SCHED && aux0_r[AUX0_AINC])
          ptr_r <= ptr_r + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// File: lmbi_mcu.sv
// microcontroller end: runs one bus cycle per command
`default_nettype none
module lmbi_mcu (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [1:0] ua_addr,
  input  wire logic [7:0] ua_wdata,
  input  wire logic       ua_we,
  input  wire logic       ua_re,
  output logic [7:0]      ua_rdata,
  lmbi_if.mcu             bus
);
  import lmbi_pkg::*;

  lmbi_hstate_t st_r;
  logic [3:0]   cnt_r;
  logic [7:0]   tgt_r;
  logic [7:0]   wd_r;
  logic [7:0]   rdat_r;
  logic         read_r;
  logic         moto_r;
  logic         mux_r;
  logic         go;

  assign go = ua_we && ua_addr == H_CTRL && ua_wdata[HC_GO] &&
              st_r == H_IDLE;

  // ------------------------------------------------------------
  // command registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tgt_r    <= 8'h00;
      wd_r     <= 8'h00;
      read_r   <= 1'b0;
      moto_r   <= 1'b0;
      mux_r    <= 1'b0;
      ua_rdata <= 8'h00;
    end else begin
      if (ua_we && ua_addr == H_ADDR)
        tgt_r <= ua_wdata;
      if (ua_we && ua_addr == H_WDATA)
        wd_r <= ua_wdata;
      // mode changes only between cycles
      if (ua_we && ua_addr == H_CTRL && st_r == H_IDLE) begin
        read_r <= ua_wdata[HC_READ];
        moto_r <= ua_wdata[HC_MOTO];
        mux_r  <= ua_wdata[HC_MUX];
      end
      if (ua_re) begin
        case (ua_addr)
          H_ADDR:  ua_rdata <= tgt_r;
          H_WDATA: ua_rdata <= wd_r;
          H_CTRL:  ua_rdata <= {4'h0, mux_r, moto_r, read_r,
                                st_r != H_IDLE};
          default: ua_rdata <= rdat_r;
        endcase
      end else begin
        ua_rdata <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // bus cycle sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r                    <= H_IDLE;
      cnt_r                   <= 4'h0;
      rdat_r                  <= 8'h00;
      bus.ale                 <= 1'b0;
      bus.addr                <= 8'h00;
      bus.ad_m                <= 8'h00;
      bus.ad_m_oe             <= 1'b0;
      bus.write_dir_n         <= 1'b1;
      bus.read_or_data_strobe <= 1'b1;
    end else begin
      case (st_r)
        H_IDLE: begin
          bus.ad_m_oe             <= 1'b0;
          bus.write_dir_n         <= 1'b1;
          bus.read_or_data_strobe <= !moto_r;
          cnt_r                   <= PHASE_CYC - 4'h1;
          if (go) begin
            bus.addr <= tgt_r;
            if (mux_r) begin
              st_r        <= H_ALE;
              bus.ale     <= 1'b1;
              bus.ad_m    <= tgt_r;
              bus.ad_m_oe <= 1'b1;
            end else begin
              st_r <= H_GAP;
            end
          end
        end
        H_ALE: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h0) begin
            st_r    <= H_GAP;
            bus.ale <= 1'b0;
          end
        end
        H_GAP: begin
          // address stays on the pins one cycle after latch falls
          st_r        <= H_STRB;
          cnt_r       <= PHASE_CYC - 4'h1;
          bus.ad_m    <= wd_r;
          bus.ad_m_oe <= !read_r;
          if (moto_r) begin
            bus.write_dir_n         <= read_r;
            bus.read_or_data_strobe <= 1'b1;
          end else if (read_r) begin
            bus.read_or_data_strobe <= 1'b0;
          end else begin
            bus.write_dir_n <= 1'b0;
          end
        end
        H_STRB: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h0) begin
            st_r   <= H_END;
            rdat_r <= read_r ? bus.ad : rdat_r;
            if (moto_r)
              bus.read_or_data_strobe <= 1'b0;
            else begin
              bus.read_or_data_strobe <= 1'b1;
              bus.write_dir_n         <= 1'b1;
            end
          end
        end
        H_END: begin
          // write data held past the closing strobe edge
          st_r                    <= H_IDLE;
          bus.ad_m_oe             <= 1'b0;
          bus.write_dir_n         <= 1'b1;
          bus.read_or_data_strobe <= !moto_r;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: lmbi_sva.sv
// pin-level checks between the controller end and the device end
`default_nettype none
module lmbi_sva (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       ale,
  input wire logic [7:0] addr,
  input wire logic [7:0] ad_m,
  input wire logic       ad_m_oe,
  input wire logic       ad_d_oe,
  input wire logic       write_dir_n,
  input wire logic       read_or_data_strobe,
  input wire logic [7:0] bd
);
  import lmbi_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic      first_r, sep_r, mux_r;
  wire logic stb = read_or_data_strobe;
  // read strobe active in the captured style
  wire logic act = sep_r ? !stb : (stb && write_dir_n);
  // ------------------------------------------------------------
  // strap copy
  // ------------------------------------------------------------
  // kept apart from the device so a wrong capture there shows up here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      first_r <= 1'b1;
      sep_r   <= 1'b0;
      mux_r   <= 1'b0;
    end else if (first_r) begin
      first_r <= 1'b0;
      sep_r   <= bd[BD_STYLE];
      mux_r   <= bd[BD_MUX];
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_rd_held;
    act [*2];
  endsequence
  sequence s_wr_tail;
    !write_dir_n [*2] ##1 write_dir_n;
  endsequence
  a_bus_contention: assert property (!(ad_d_oe && ad_m_oe))
    else $error("both ends drive the data bus");
  a_drive_cause: assert property (
    ad_d_oe |-> $past(act) || $past(act, 2))
    else $error("device drives without a read strobe");
  a_read_answer: assert property (
    s_rd_held ##0 (!mux_r && addr == OFF_AUX0) |-> ##[0:1] ad_d_oe)
    else $error("decoded read not answered");
  a_quiet_low: assert property (
    s_rd_held ##0 (!mux_r && addr < DEC_LO) |-> !ad_d_oe)
    else $error("device answers below its range");
  a_strobe_width: assert property (
    (sep_r ? $fell(stb) : $rose(stb))
      |=> $stable(stb) [*2] ##1 $changed(stb))
    else $error("data strobe not three cycles");
  a_wr_width: assert property (
    sep_r && $fell(write_dir_n) |=> s_wr_tail)
    else $error("write strobe not three cycles");
  a_write_hold: assert property (
    sep_r && $rose(write_dir_n) |-> ad_m_oe && $stable(ad_m))
    else $error("write data gone at strobe release");
  a_ale_owns: assert property (ale |-> ad_m_oe && !ad_d_oe)
    else $error("address phase without controller drive");
endmodule
`default_nettype wire

// File: lmbi_tb.sv
// self-checking bench: both ends joined back to back
`default_nettype none
module lmbi_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lmbi_pkg::*;
  logic        clock, rst, ua_we, ua_re, want, look, hrst, hcmd, hsoft;
  logic        buf_req, buf_ack, io, ioe, bsch, bwe;
  logic        sep, mux, pdl, pda, pdd;
  logic [11:0] isrc;
  logic [15:0] baddr;
  logic [1:0]  ua_addr, mode;
  logic [7:0]  ua_wdata, ua_rdata, buf_rdata, sw, v, bwd;
  logic [7:0]  q[$];
  int          err_count, samples_checked, seed;
  // value, expected readback, unlock first, wake cause
  logic [19:0] pw [7] = '{20'h20001, 20'h20000, 20'h20204, 20'h40401,
                          20'h40002, 20'h80802, 20'h80003};
  lmbi_if bus_if ();
  lmbi_dev lmbi_dev_inst (
    .clock(clock), .rst(rst), .bus(bus_if), .host_reset_pin(hrst),
    .host_cmd_wr(hcmd), .host_soft_reset(hsoft), .irq_src(isrc),
    .irq_o(io), .irq_oe(ioe), .buf_req(buf_req), .buf_sched(bsch),
    .buf_we(bwe), .buf_addr(baddr), .buf_wdata(bwd), .buf_ack(buf_ack),
    .buf_rdata(buf_rdata), .pd_local(pdl), .pd_ata(pda), .pd_deep(pdd),
    .sep_strobe(sep), .mux_mode(mux)
  );
  lmbi_mcu lmbi_mcu_inst (
    .clock(clock), .rst(rst), .ua_addr(ua_addr), .ua_wdata(ua_wdata),
    .ua_we(ua_we), .ua_re(ua_re), .ua_rdata(ua_rdata), .bus(bus_if)
  );
  lmbi_sva lmbi_sva_inst (
    .clock(clock), .rst(rst), .ale(bus_if.ale), .addr(bus_if.addr),
    .ad_m(bus_if.ad_m), .ad_m_oe(bus_if.ad_m_oe),
    .ad_d_oe(bus_if.ad_d_oe), .write_dir_n(bus_if.write_dir_n),
    .read_or_data_strobe(bus_if.read_or_data_strobe), .bd(bus_if.bd)
  );
  // ------------------------------------------------------------
  // clock, buffer responder, result monitor
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    buf_ack <= buf_req & ~buf_ack;
    buf_rdata <= 8'($random(seed));
  end
  // a read result stands only in the cycle after the read strobe
  always @(negedge clock) begin
    if (look) begin
      samples_checked++;
      if (q.size() == 0 || ua_rdata !== q[0]) begin
        err_count++;
        $display("mismatch at %0t: read %h", $time, ua_rdata);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
    look = ua_re & want;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // direct look at settled side outputs; callers sample off the edge except after start or a read
  task automatic chk(input logic [25:0] g, input logic [25:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: output %h", $time, g);
    end
  endtask
  task automatic cyc(input logic [1:0] a, input logic [7:0] d,
                     input logic r, input logic w);
    @(posedge clock);
    ua_addr <= a;
    ua_wdata <= d;
    ua_we <= !r;
    ua_re <= r;
    want <= w;
    @(posedge clock);
    ua_we <= 1'b0;
    ua_re <= 1'b0;
  endtask
  // one device access; a read notes its expected byte
  task automatic op(input logic [7:0] a, input logic [7:0] d,
                    input logic r, input logic [7:0] e);
    int n;
    cyc(H_ADDR, a, 1'b0, 1'b0);
    cyc(H_WDATA, d, 1'b0, 1'b0);
    cyc(H_CTRL, {4'h0, mode, r, 1'b1}, 1'b0, 1'b0);
    n = 0;
    do begin
      cyc(H_CTRL, 8'h00, 1'b1, 1'b0);
      @(negedge clock);
      n++;
    end while (ua_rdata[0] !== 1'b0 && n < 50);
    if (n == 50) begin
      err_count++;
      $display("mismatch at %0t: controller stuck busy", $time);
      finish_test();
    end else if (r) begin
      q.push_back(e);
      cyc(H_RDATA, 8'h00, 1'b1, 1'b1);
    end
  endtask
  task automatic wake(input logic [1:0] c);
    @(posedge clock);
    hcmd <= (c == 2'd1);
    hsoft <= (c == 2'd2);
    hrst <= (c == 2'd3);
    @(posedge clock);
    {hcmd, hsoft, hrst} <= 3'b000;
  endtask
  // straps must already stand when reset is released
  // one edge first, so the last read result is not cleared under the monitor
  task automatic start(input logic [7:0] b, input logic [1:0] m);
    @(posedge clock);
    rst <= 1'b1;
    bus_if.bd <= b;
    mode = m;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    cyc(H_CTRL, {4'h0, m, 2'b00}, 1'b0, 1'b0);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hfd870973;
    {ua_we, ua_re, want, look, hrst, hcmd, hsoft, buf_ack} = '0;
    rst = 1'b1;
    isrc = '0;
    ua_addr = '0;
    ua_wdata = '0;
    buf_rdata = '0;
    for (int p = 0; p < 2; p++) begin
      sw = 8'($random(seed));
      v = 8'($random(seed));
      start(p ? {3'b100, sw[4:0]} : {3'b010, sw[4:0]}, p ? 2'b11 : 2'b00);
      chk({24'h0, sep, mux}, p ? 26'h1 : 26'h2);
      op(OFF_AUX0, v, 1'b0, 8'h00);
      op(OFF_AUX0, 8'h00, 1'b1, v);
      op(8'h10, 8'h00, 1'b1, 8'hff);
      op(OFF_MISC, 8'h01, 1'b0, 8'h00);
      op(OFF_SCHED, 8'h00, 1'b1, {3'h0, sw[4:0]});
      op(OFF_UNSCHED, 8'h00, 1'b1, {3'h0, sw[4:0]});
    end
    op(OFF_AUX0, 8'h00, 1'b0, 8'h00);
    op(8'h40, 8'h00, 1'b1, 8'hff);
    op(OFF_SH_BUF, 8'h5a, 1'b0, 8'h00);
    op(OFF_AUX0, 8'h02, 1'b0, 8'h00);
    op(OFF_SH_BUF, 8'ha5, 1'b0, 8'h00);
    op(OFF_SH_BUF, 8'h00, 1'b1, 8'ha5);
    op(OFF_AUX0, 8'h00, 1'b0, 8'h00);
    op(OFF_SH_BUF, 8'h00, 1'b1, 8'h5a);
    op(OFF_AUX1, 8'h00, 1'b0, 8'h00);
    op(8'h40, 8'h3c, 1'b0, 8'h00);
    op(8'h40, 8'h00, 1'b1, 8'h3c);
    op(OFF_AUX1, 8'h01, 1'b0, 8'h00);
    op(8'h20, 8'h00, 1'b1, 8'hff);
    foreach (pw[i]) begin
      if (pw[i][2]) op(OFF_UNLOCK, 8'h00, 1'b0, 8'h00);
      op(OFF_AUX1, pw[i][19:12], 1'b0, 8'h00);
      wake(pw[i][1:0]);
      op(OFF_AUX1, 8'h00, 1'b1, pw[i][11:4]);
      chk({23'h0, pdd, pda, pdl}, 26'(pw[i][11:9]));
    end
    // buffer ports with the switches off the bus; no disk transfer runs
    op(OFF_MISC, 8'h00, 1'b0, 8'h00);
    op(OFF_AUX0, 8'h01, 1'b0, 8'h00);
    op(OFF_PTR_LO, 8'h10, 1'b0, 8'h00);
    op(OFF_SCHED, 8'h77, 1'b0, 8'h00);
    chk({bsch, bwe, baddr, bwd}, {2'b11, 16'h0010, 8'h77});
    op(OFF_PTR_LO, 8'h00, 1'b1, 8'h11);
    op(OFF_UNSCHED, 8'h66, 1'b0, 8'h00);
    chk({bsch, bwe, baddr, bwd}, {2'b01, 16'h0011, 8'h66});
    op(OFF_PTR_LO, 8'h00, 1'b1, 8'h11);
    // interrupts: push-pull, then open-drain, then cleared
    op(OFF_IMSK_LO, 8'h01, 1'b0, 8'h00);
    op(OFF_ICTL, 8'h01, 1'b0, 8'h00);
    @(posedge clock);
    isrc <= 12'h001;
    @(posedge clock);
    isrc <= 12'h000;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk({24'h0, io, ioe}, 26'h3);
    op(OFF_ICTL, 8'h03, 1'b0, 8'h00);
    chk({24'h0, io, ioe}, 26'h1);
    op(OFF_IST_LO, 8'h00, 1'b1, 8'h01);
    op(OFF_IST_LO, 8'h01, 1'b0, 8'h00);
    chk({24'h0, io, ioe}, 26'h0);
    repeat (3) @(posedge clock);
    finish_test();
  end
endmodule
`default_nettype wire
